// file: rtl/ccp_compare_pwm.sv
// compare and pulse-width unit: register port, compare engine, pwm engine
// assumes a byte register port on CLK and an external pin that reads PIN_DIR_N low as output
// Operation
// [RULE1] compare 16-bit value with timer1, act on pin
// [RULE2] match sets event flag with pin action
// [RULE3] zero control write clears compare latch
// [RULE4] software-interrupt mode only sets flag
// [RULE5] trigger clears timer1, starts converter
// [RULE6] trigger reset never sets timer1 overflow
// [RULE7] software runs timer1 synchronously
// [RULE8] software sets pin direction to output
// [RULE9] pwm output with 10-bit resolution; at 1:1 prescale the code gives only 8-bit resolution
// [RULE10] period end clears timer2, sets pin
// [RULE11] period end loads duty into active copy
// [RULE12] postscaler never affects pwm period
// [RULE13] duty is low byte plus control 5:4
// [RULE14] new duty applies only after period end
// [RULE15] high byte read-only in pwm mode
// [RULE16] duty double-buffered for glitch-free output
// [RULE17] clear pin when duty equals extended timer2
// [RULE18] duty above period keeps pin high
// [RULE19] zero control write clears pwm latch
// [RULE20] mode field decodes six modes
// [RULE21] off mode releases pin to port
`timescale 1ns/10ps
module ccp_compare_pwm (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic ADC_ENABLE,
    output logic [7:0] RDATA,
    output logic CCP_PIN_OUT,
    output logic CCP_PIN_ACTIVE,
    output logic ADC_START,
    output logic CCP_IRQ
);
    logic [7:0] low_reg;
    logic [7:0] high_reg;
    logic [7:0] ctl_reg;
    logic [7:0] flags_reg;
    logic [7:0] enables_reg;
    logic [7:0] t2ctl_reg;
    logic [7:0] period_reg;
    logic [7:0] t1ctl_reg;
    logic [1:0] fine_reg;
    logic cmp_latch_reg;
    logic pwm_latch_reg;
    logic match_prev_reg;
    logic pwm_start_reg;
    logic [7:0] rdata_next;
    logic [7:0] flags_next;
    ccp_bus_if tbus ();

    // decode of strobes and mode
    logic wr_low, wr_high, wr_ctl, wr_flags, wr_en, wr_t2ctl, wr_period, wr_t1ctl;
    ccp_pkg::ccp_mode_t mode;
    logic is_cmp, is_pwm, is_off;
    logic match_level, match_pulse;
    logic [9:0] duty_active;
    logic [9:0] fine_count;
    logic pwm_clear, pwm_set;
    logic fine_direct;
    assign wr_low = WR && (ADDR == ccp_pkg::ADDR_CCPL);
    // high byte writes are dropped in pwm mode [RULE15]
    assign wr_high = WR && (ADDR == ccp_pkg::ADDR_CCPH) && !is_pwm;
    assign wr_ctl = WR && (ADDR == ccp_pkg::ADDR_CCPCTL);
    assign wr_flags = WR && (ADDR == ccp_pkg::ADDR_FLAGS);
    assign wr_en = WR && (ADDR == ccp_pkg::ADDR_ENABLES);
    assign wr_t2ctl = WR && (ADDR == ccp_pkg::ADDR_T2CTL);
    assign wr_period = WR && (ADDR == ccp_pkg::ADDR_PERIOD);
    assign wr_t1ctl = WR && (ADDR == ccp_pkg::ADDR_T1CTL);
    // undefined codes behave as off [RULE20]
    assign mode = ccp_pkg::ccp_mode_t'(ctl_reg[3:0]);
    assign is_cmp = (mode == ccp_pkg::MODE_SET) || (mode == ccp_pkg::MODE_CLR) || (mode == ccp_pkg::MODE_SWI)
        || (mode == ccp_pkg::MODE_SPEV); // [RULE20]
    assign is_pwm = (mode == ccp_pkg::MODE_PWM); // [RULE20]
    assign is_off = !is_cmp && !is_pwm; // [RULE21]

    // continuous 16-bit equality, acted on once per arrival at the value
    assign match_level = is_cmp && ({high_reg, low_reg} == tbus.t1_count); // [RULE1]
    assign match_pulse = match_level && !match_prev_reg;
    assign tbus.t1_clear = match_pulse && (mode == ccp_pkg::MODE_SPEV); // [RULE5]

    // pwm: active copy is high byte plus internal 2-bit latch [RULE16] [RULE13]
    assign duty_active = {high_reg, fine_reg};
    // 1:1 prescale has no phase bits, so the copy's own low bits stand in and resolution drops to the count
    assign fine_direct = (t2ctl_reg[1:0] == 2'b00);
    assign fine_count = {tbus.t2_count, fine_direct ? fine_reg : tbus.t2_fine}; // [RULE17]
    // a duty above the period never matches, so the pin never clears [RULE18]
    assign pwm_clear = is_pwm && (duty_active == fine_count); // [RULE17]
    // zero duty never sets the pin [RULE10]
    assign pwm_set = is_pwm && tbus.t2_period_end && ({low_reg, ctl_reg[5:4]} != 10'h000);

    ccp_timers u_timers (
        .CLK(CLK),
        .RESET_N(RESET_N),
        .t1_run(t1ctl_reg[ccp_pkg::T1_ON_BIT]),
        .t1_wr_lo(WR && (ADDR == ccp_pkg::ADDR_T1L)),
        .t1_wr_hi(WR && (ADDR == ccp_pkg::ADDR_T1H)),
        .t2_wr(WR && (ADDR == ccp_pkg::ADDR_TIMER2_COUNT)),
        .wdata(WDATA),
        .t2_control(t2ctl_reg),
        .period(period_reg),
        .tb(tbus.timers)
    );

    // flags: hardware set wins over a software clear in the same cycle
    always_comb begin
        flags_next = flags_reg;
        if (wr_flags) begin
            flags_next = WDATA & 8'h07;
        end
        if (match_pulse) begin
            flags_next[ccp_pkg::FLAG_CCP_BIT] = 1'b1; // [RULE2] [RULE4]
        end
        if (tbus.t1_wrap) begin
            flags_next[ccp_pkg::FLAG_T1OVF_BIT] = 1'b1; // [RULE6]
        end
        if (tbus.t2_period_end) begin
            flags_next[ccp_pkg::FLAG_T2MATCH_BIT] = 1'b1;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        case (ADDR)
            ccp_pkg::ADDR_FLAGS: rdata_next = flags_reg;
            ccp_pkg::ADDR_TIMER2_COUNT: rdata_next = tbus.t2_count;
            ccp_pkg::ADDR_T2CTL: rdata_next = t2ctl_reg;
            ccp_pkg::ADDR_CCPL: rdata_next = low_reg;
            ccp_pkg::ADDR_CCPH: rdata_next = high_reg;
            ccp_pkg::ADDR_CCPCTL: rdata_next = ctl_reg;
            ccp_pkg::ADDR_ENABLES: rdata_next = enables_reg;
            ccp_pkg::ADDR_PERIOD: rdata_next = period_reg;
            ccp_pkg::ADDR_T1L: rdata_next = tbus.t1_count[7:0];
            ccp_pkg::ADDR_T1H: rdata_next = tbus.t1_count[15:8];
            ccp_pkg::ADDR_T1CTL: rdata_next = t1ctl_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // plain configuration registers
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ctl_reg <= ccp_pkg::ZERO_RESET;
            enables_reg <= ccp_pkg::ZERO_RESET;
            t2ctl_reg <= ccp_pkg::ZERO_RESET;
            period_reg <= ccp_pkg::PERIOD_RESET;
            t1ctl_reg <= ccp_pkg::ZERO_RESET;
            flags_reg <= ccp_pkg::ZERO_RESET;
            low_reg <= ccp_pkg::ZERO_RESET;
        end else begin
            flags_reg <= flags_next;
            if (wr_ctl) ctl_reg <= WDATA & 8'h3f;
            if (wr_en) enables_reg <= WDATA & 8'h07;
            if (wr_t2ctl) t2ctl_reg <= WDATA & 8'h7f;
            if (wr_period) period_reg <= WDATA;
            if (wr_t1ctl) t1ctl_reg <= WDATA & 8'h01;
            if (wr_low) low_reg <= WDATA; // [RULE14] takes effect only at period end in pwm
        end
    end

    // active duty copy: loaded at period end in pwm mode, otherwise written as the high byte
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            high_reg <= ccp_pkg::ZERO_RESET;
            fine_reg <= 2'h0;
        end else if (is_pwm && tbus.t2_period_end) begin
            high_reg <= low_reg; // [RULE11] [RULE14]
            fine_reg <= ctl_reg[5:4]; // [RULE11] [RULE16]
        end else if (wr_high) begin
            high_reg <= WDATA;
        end
    end

    // compare output latch
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            cmp_latch_reg <= 1'b0;
            match_prev_reg <= 1'b0;
        end else begin
            match_prev_reg <= match_level;
            if (wr_ctl && (WDATA == 8'h00)) begin
                cmp_latch_reg <= 1'b0; // [RULE3]
            end else if (match_pulse && (mode == ccp_pkg::MODE_SET)) begin
                cmp_latch_reg <= 1'b1; // [RULE1]
            end else if (match_pulse && (mode == ccp_pkg::MODE_CLR)) begin
                cmp_latch_reg <= 1'b0; // [RULE1]
            end
        end
    end

    // pwm output latch: the set waits one cycle so the high time is exactly the duty count;
    // a clear in that same cycle wins, so a duty below one step never latches high
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            pwm_start_reg <= 1'b0;
            pwm_latch_reg <= 1'b0;
        end else begin
            pwm_start_reg <= pwm_set; // [RULE10]
            if ((wr_ctl && (WDATA == 8'h00)) || !is_pwm) begin
                pwm_latch_reg <= 1'b0; // [RULE19]
            end else if (pwm_clear) begin
                pwm_latch_reg <= 1'b0; // [RULE17]
            end else if (pwm_start_reg) begin
                pwm_latch_reg <= 1'b1; // [RULE9] [RULE10]
            end
        end
    end

    // registered outputs
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            RDATA <= 8'h00;
            CCP_PIN_OUT <= 1'b0;
            CCP_PIN_ACTIVE <= 1'b0;
            ADC_START <= 1'b0;
            CCP_IRQ <= 1'b0;
        end else begin
            RDATA <= RD ? rdata_next : 8'h00;
            CCP_PIN_OUT <= is_pwm ? pwm_latch_reg : cmp_latch_reg;
            // swi and off modes leave the pin to the port [RULE4] [RULE21]
            CCP_PIN_ACTIVE <= is_pwm || (mode == ccp_pkg::MODE_SET) || (mode == ccp_pkg::MODE_CLR)
                || (mode == ccp_pkg::MODE_SPEV);
            ADC_START <= tbus.t1_clear && ADC_ENABLE; // [RULE5]
            CCP_IRQ <= flags_reg[ccp_pkg::FLAG_CCP_BIT] && enables_reg[ccp_pkg::FLAG_CCP_BIT]; // [RULE4]
        end
    end
endmodule : ccp_compare_pwm

// file: rtl/ccp_pkg.sv
// constants for the compare and pwm unit
// assumes a byte-wide register port and a single 40 MHz clock
package ccp_pkg;
    // register offsets
    localparam logic [7:0] ADDR_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_TIMER2_COUNT = 8'h11;
    localparam logic [7:0] ADDR_T2CTL = 8'h12;
    localparam logic [7:0] ADDR_CCPL = 8'h15;
    localparam logic [7:0] ADDR_CCPH = 8'h16;
    localparam logic [7:0] ADDR_CCPCTL = 8'h17;
    localparam logic [7:0] ADDR_ENABLES = 8'h8c;
    localparam logic [7:0] ADDR_PERIOD = 8'h92;
    localparam logic [7:0] ADDR_T1L = 8'he0;
    localparam logic [7:0] ADDR_T1H = 8'he1;
    localparam logic [7:0] ADDR_T1CTL = 8'he2;
    // field positions
    localparam int FLAG_T1OVF_BIT = 0;
    localparam int FLAG_T2MATCH_BIT = 1;
    localparam int FLAG_CCP_BIT = 2;
    localparam int T2_ON_BIT = 2;
    localparam int T1_ON_BIT = 0;
    // reset values
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [7:0] ZERO_RESET = 8'h00;
    // mode field encodings
    typedef enum logic [3:0] {
        MODE_OFF = 4'b0000,
        MODE_SET = 4'b1000,
        MODE_CLR = 4'b1001,
        MODE_SWI = 4'b1010,
        MODE_SPEV = 4'b1011,
        MODE_PWM = 4'b1100
    } ccp_mode_t;
endpackage : ccp_pkg

// file: rtl/ccp_bus_if.sv
// carrier for timer state shared between the timers and the core
// assumes both ends run on CLK
`timescale 1ns/10ps
interface ccp_bus_if;
    logic [15:0] t1_count;
    logic t1_clear;
    logic t1_wrap;
    logic [7:0] t2_count;
    logic [1:0] t2_fine;
    logic t2_period_end;
    modport timers (output t1_count, output t1_wrap, output t2_count, output t2_fine, output t2_period_end,
        input t1_clear);
    modport core (input t1_count, input t1_wrap, input t2_count, input t2_fine, input t2_period_end,
        output t1_clear);
endinterface : ccp_bus_if

// file: rtl/ccp_timers.sv
// timer1 and timer2 time bases for the compare and pwm unit
// assumes writes arrive from the core register port on CLK
`timescale 1ns/10ps
module ccp_timers (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic t1_run,
    input wire logic t1_wr_lo,
    input wire logic t1_wr_hi,
    input wire logic t2_wr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] t2_control,
    input wire logic [7:0] period,
    ccp_bus_if.timers tb
);
    logic [15:0] t1_reg;
    logic [7:0] t2_reg;
    logic [3:0] pre_reg;
    logic t2_on;
    logic [3:0] pre_top;
    logic pre_tick;
    logic at_period;

    // prescale 1, 4 or 16 selected by the two low control bits
    assign t2_on = t2_control[ccp_pkg::T2_ON_BIT];
    assign pre_top = (t2_control[1:0] == 2'b00) ? 4'h0 : (t2_control[1:0] == 2'b01) ? 4'h3 : 4'hf;
    assign pre_tick = t2_on && (pre_reg == pre_top);
    assign at_period = (t2_reg == period);
    // postscaler is deliberately absent: it never shapes the pwm period [RULE12]
    assign tb.t2_period_end = pre_tick && at_period;
    assign tb.t2_count = t2_reg;
    // fine bits: prescaler phase, or fixed phase for 1:1 prescale
    assign tb.t2_fine = (t2_control[1:0] == 2'b00) ? 2'h0 : pre_reg[3:2] & {2{t2_control[1]}} | pre_reg[1:0] & {2{~t2_control[1]}};
    assign tb.t1_count = t1_reg;
    // overflow only on a natural wrap, never on the trigger reset [RULE6]
    assign tb.t1_wrap = t1_run && (t1_reg == 16'hffff) && !tb.t1_clear;

    // timer2 with prescaler
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            t2_reg <= ccp_pkg::ZERO_RESET;
            pre_reg <= 4'h0;
        end else if (t2_wr) begin
            t2_reg <= wdata;
            pre_reg <= 4'h0;
        end else if (t2_on) begin
            pre_reg <= pre_tick ? 4'h0 : pre_reg + 4'h1;
            if (pre_tick) begin
                t2_reg <= at_period ? 8'h00 : t2_reg + 8'h01; // [RULE10]
            end
        end
    end

    // timer1, synchronous timer mode only
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            t1_reg <= 16'h0000;
        end else if (tb.t1_clear) begin
            t1_reg <= 16'h0000; // [RULE5]
        end else if (t1_wr_lo) begin
            t1_reg <= {t1_reg[15:8], wdata};
        end else if (t1_wr_hi) begin
            t1_reg <= {wdata, t1_reg[7:0]};
        end else if (t1_run) begin
            t1_reg <= t1_reg + 16'h0001;
        end
    end
endmodule : ccp_timers

// file: tb/ccp_compare_pwm_checker.sv
// port-level assertions for the compare and pwm unit
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module ccp_compare_pwm_checker (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic ADC_ENABLE,
    input wire logic [7:0] RDATA,
    input wire logic CCP_PIN_OUT,
    input wire logic CCP_PIN_ACTIVE,
    input wire logic ADC_START,
    input wire logic CCP_IRQ
);
    logic [3:0] mode_reg;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // mode as software last wrote it; the ports alone do not show it
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            mode_reg <= 4'h0;
        end else if (WR && ADDR == ccp_pkg::ADDR_CCPCTL) begin
            mode_reg <= WDATA[3:0];
        end
    end
    property p_adc_pulse;
        ADC_START |=> !ADC_START;
    endproperty
    a_adc_pulse: assert property (p_adc_pulse) else $error("trigger pulse too long");
    property p_adc_enable;
        ADC_START |-> $past(ADC_ENABLE) && mode_reg == ccp_pkg::MODE_SPEV;
    endproperty
    a_adc_enable: assert property (p_adc_enable) else $error("trigger without special mode");
    property p_zero_ctl;
        (WR && ADDR == ccp_pkg::ADDR_CCPCTL && WDATA == 8'h00) |-> ##[1:3] (!CCP_PIN_OUT && !CCP_PIN_ACTIVE);
    endproperty
    a_zero_ctl: assert property (p_zero_ctl) else $error("output latch kept after clear");
    property p_off_passive;
        (mode_reg == ccp_pkg::MODE_OFF)[*4] |-> !CCP_PIN_ACTIVE && !CCP_PIN_OUT;
    endproperty
    a_off_passive: assert property (p_off_passive) else $error("pin held while off");
    property p_swi_passive;
        (mode_reg == ccp_pkg::MODE_SWI)[*4] |-> !CCP_PIN_ACTIVE;
    endproperty
    a_swi_passive: assert property (p_swi_passive) else $error("pin owned in flag-only mode");
    property p_swi_stable;
        (mode_reg == ccp_pkg::MODE_SWI)[*4] |-> $stable(CCP_PIN_OUT);
    endproperty
    a_swi_stable: assert property (p_swi_stable) else $error("pin moved in flag-only mode");
    property p_set_no_fall;
        (mode_reg == ccp_pkg::MODE_SET)[*4] |-> !$fell(CCP_PIN_OUT);
    endproperty
    a_set_no_fall: assert property (p_set_no_fall) else $error("pin fell in set mode");
    property p_clr_no_rise;
        (mode_reg == ccp_pkg::MODE_CLR)[*4] |-> !$rose(CCP_PIN_OUT);
    endproperty
    a_clr_no_rise: assert property (p_clr_no_rise) else $error("pin rose in clear mode");
endmodule : ccp_compare_pwm_checker
bind ccp_compare_pwm ccp_compare_pwm_checker u_checker (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .ADC_ENABLE(ADC_ENABLE), .RDATA(RDATA), .CCP_PIN_OUT(CCP_PIN_OUT),
    .CCP_PIN_ACTIVE(CCP_PIN_ACTIVE), .ADC_START(ADC_START), .CCP_IRQ(CCP_IRQ));

// file: tb/ccp_pin_load.sv
// external load on the shared pin, with the port latch and direction behind it
// assumes the unit's pin outputs are registered on the same clock
`timescale 1ns/10ps
module ccp_pin_load (
    input wire logic clk,
    input wire logic pin_out,
    input wire logic pin_active,
    input wire logic port_dir_n,
    input wire logic port_latch,
    output logic pin_level
);
    logic last_reg = 1'b0;
    // nothing reaches the wire unless the direction is output
    // a floating pin shows the inverse of its last level, so no stale value passes
    assign pin_level = port_dir_n ? ~last_reg : (pin_active ? pin_out : port_latch);
    always @(posedge clk) begin
        last_reg <= pin_level;
    end
endmodule : ccp_pin_load

// file: tb/tb_compare_and_pwm_unit.sv
// self-checking bench for the compare and pwm unit
// assumes the register map and mode codes of ccp_pkg and a 40 MHz clock
`timescale 1ns/10ps
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected %s: expected %h seen %h", what, exp, got); end end
module tb_compare_and_pwm_unit;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic adc_enable = 1'b0;
    logic port_dir_n = 1'b1;
    logic [7:0] rdata;
    logic pin_out, pin_active, adc_start, irq, pin_level;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    ccp_compare_pwm u_dut (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .ADC_ENABLE(adc_enable), .RDATA(rdata), .CCP_PIN_OUT(pin_out), .CCP_PIN_ACTIVE(pin_active),
        .ADC_START(adc_start), .CCP_IRQ(irq));
    ccp_pin_load u_load (.clk(clk), .pin_out(pin_out), .pin_active(pin_active), .port_dir_n(port_dir_n),
        .port_latch(1'b0), .pin_level(pin_level));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic wait_pin(input logic v);
        int n;
        n = 0;
        // step off the launching edge before the first look
        #1;
        while (pin_out !== v && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("pin", v, pin_out)
    endtask : wait_pin
    // timer1 stopped while reloaded, so it runs from clk only
    task automatic t1_restart();
        wr_reg(ccp_pkg::ADDR_T1CTL, 8'h00);
        wr_reg(ccp_pkg::ADDR_T1L, 8'h00);
        wr_reg(ccp_pkg::ADDR_T1H, 8'h00);
        wr_reg(ccp_pkg::ADDR_T1CTL, 8'h01);
    endtask : t1_restart
    // settle past one period of 40 cycles, then count high cycles over two periods
    task automatic measure(input int exp_hi);
        int hi;
        hi = 0;
        repeat (45) @(posedge clk);
        repeat (80) begin
            @(posedge clk);
            #1;
            if (pin_level === 1'b1) hi++;
        end
        `CHK("high cycles", exp_hi, hi)
    endtask : measure
    task automatic t_compare();
        logic [7:0] d;
        rd_reg(ccp_pkg::ADDR_PERIOD, d);
        `CHK("period reset", ccp_pkg::PERIOD_RESET, d)
        rd_reg(8'hf0, d);
        `CHK("unmapped read", 8'h00, d)
        wr_reg(ccp_pkg::ADDR_CCPL, 8'h10);
        wr_reg(ccp_pkg::ADDR_CCPH, 8'h00);
        wr_reg(ccp_pkg::ADDR_ENABLES, 8'h04);
        wr_reg(ccp_pkg::ADDR_CCPCTL, {4'h0, ccp_pkg::MODE_SET});
        t1_restart();
        wait_pin(1'b1);
        rd_reg(ccp_pkg::ADDR_FLAGS, d);
        `CHK("event flag", 1'b1, d[ccp_pkg::FLAG_CCP_BIT])
        `CHK("irq", 1'b1, irq)
        wr_reg(ccp_pkg::ADDR_CCPCTL, 8'h00);
        wait_pin(1'b0);
        wr_reg(ccp_pkg::ADDR_CCPCTL, {4'h0, ccp_pkg::MODE_SET});
        t1_restart();
        wait_pin(1'b1);
        wr_reg(ccp_pkg::ADDR_CCPCTL, {4'h0, ccp_pkg::MODE_CLR});
        t1_restart();
        wait_pin(1'b0);
        wr_reg(ccp_pkg::ADDR_FLAGS, 8'h00);
        wr_reg(ccp_pkg::ADDR_CCPCTL, {4'h0, ccp_pkg::MODE_SWI});
        t1_restart();
        repeat (40) @(posedge clk);
        rd_reg(ccp_pkg::ADDR_FLAGS, d);
        `CHK("flag only", 1'b1, d[ccp_pkg::FLAG_CCP_BIT])
        `CHK("pin untouched", 1'b0, pin_active)
        $display("done compare");
    endtask : t_compare
    task automatic t_special();
        logic [7:0] d;
        int n;
        wr_reg(ccp_pkg::ADDR_FLAGS, 8'h00);
        // match at the top count, so a natural wrap and the trigger fall on one edge
        wr_reg(ccp_pkg::ADDR_CCPL, 8'hff);
        wr_reg(ccp_pkg::ADDR_CCPH, 8'hff);
        adc_enable <= 1'b1;
        wr_reg(ccp_pkg::ADDR_CCPCTL, {4'h0, ccp_pkg::MODE_SPEV});
        wr_reg(ccp_pkg::ADDR_T1CTL, 8'h00);
        wr_reg(ccp_pkg::ADDR_T1L, 8'he0);
        wr_reg(ccp_pkg::ADDR_T1H, 8'hff);
        wr_reg(ccp_pkg::ADDR_T1CTL, 8'h01);
        n = 0;
        while (adc_start !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("converter start", 1'b1, adc_start)
        rd_reg(ccp_pkg::ADDR_T1L, d);
        `CHK("timer1 cleared", 1'b1, d < 8'h10)
        rd_reg(ccp_pkg::ADDR_T1H, d);
        `CHK("timer1 high cleared", 8'h00, d)
        rd_reg(ccp_pkg::ADDR_FLAGS, d);
        `CHK("overflow flag", 1'b0, d[ccp_pkg::FLAG_T1OVF_BIT])
        wr_reg(ccp_pkg::ADDR_CCPCTL, 8'h00);
        adc_enable <= 1'b0;
        $display("done special trigger");
    endtask : t_special
    task automatic t_pwm();
        logic [7:0] d;
        port_dir_n <= 1'b0;
        wr_reg(ccp_pkg::ADDR_PERIOD, 8'h09);
        // postscaler bits set on purpose; 1:4 prescale, timer on
        wr_reg(ccp_pkg::ADDR_T2CTL, 8'h7d);
        wr_reg(ccp_pkg::ADDR_CCPL, 8'h02);
        wr_reg(ccp_pkg::ADDR_CCPCTL, {2'b00, 2'b11, ccp_pkg::MODE_PWM});
        measure(22);
        wait_pin(1'b0);
        wait_pin(1'b1);
        wr_reg(ccp_pkg::ADDR_CCPL, 8'h03);
        wr_reg(ccp_pkg::ADDR_CCPCTL, {2'b00, 2'b01, ccp_pkg::MODE_PWM});
        wr_reg(ccp_pkg::ADDR_CCPH, 8'hff);
        rd_reg(ccp_pkg::ADDR_CCPH, d);
        `CHK("active duty", 8'h02, d)
        wait_pin(1'b0);
        wait_pin(1'b1);
        rd_reg(ccp_pkg::ADDR_CCPH, d);
        `CHK("active duty", 8'h03, d)
        measure(26);
        wr_reg(ccp_pkg::ADDR_CCPL, 8'h0c);
        measure(80);
        wr_reg(ccp_pkg::ADDR_CCPL, 8'h00);
        wr_reg(ccp_pkg::ADDR_CCPCTL, {2'b00, 2'b00, ccp_pkg::MODE_PWM});
        measure(0);
        wr_reg(ccp_pkg::ADDR_CCPL, 8'h08);
        wait_pin(1'b1);
        wr_reg(ccp_pkg::ADDR_CCPCTL, 8'h00);
        wait_pin(1'b0);
        rd_reg(ccp_pkg::ADDR_CCPCTL, d);
        `CHK("pin released", 1'b0, pin_active)
        $display("done pwm");
    endtask : t_pwm
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        port_dir_n <= 1'b0;
        t_compare();
        t_special();
        t_pwm();
        end_of_test();
    end
endmodule : tb_compare_and_pwm_unit
